/* File: core/cit_pkg.sv */
/*
 * Shared constants and carrier types for the instruction timing and
 * read-modify-write sequencer of the 8-bit core.
 * Assumes one core clock, a synchronous active-high reset and a fetch
 * unit that presents one opcode byte per accepted instruction.
 */
// Overview of operation
// - one-byte register and carry ops: one cycle
// - indirect accumulator moves and swaps: two cycles
// - two-byte direct or immediate moves: two cycles
// - three-byte moves and pointer load: three cycles
// - code byte fetch into accumulator: four cycles
// - external data reads and writes: four cycles
// - stack push and pop: two bytes, two cycles
// - low nibble swap with memory: two cycles
// - two-byte bit ops: two cycles
// - indirect jump three, returns four cycles
// - two-byte control transfers: three cycles
// - three-byte control transfers: four cycles
// - plain port bit input reads the pin
// - port read-modify-write reads the latch
// - fixed list of read-modify-write opcodes
// - port bit ops rewrite the whole latched byte
// - add ignores the incoming carry
// - carry flag is carry out of bit 7
// - wrap flag is carry6 xor carry7
// - half carry is carry out of bit 3
package cit_pkg;

    // widths of the timing fields
    localparam int BYTES_W  = 2;
    localparam int CYCLES_W = 3;

    // documented carry positions of the adder
    localparam int HALF_BIT = 3;
    localparam int WRAP_BIT = 6;
    localparam int TOP_BIT  = 7;

    // reset values and the first cycle count
    localparam logic [CYCLES_W-1:0] CYCLES_RST = 3'h1;
    localparam logic [BYTES_W-1:0]  BYTES_RST  = 2'h1;
    localparam logic [CYCLES_W-1:0] COUNT_ONE  = 3'h1;

    // named opcodes; the checks refer to all but the last three
    localparam logic [7:0] OP_IDLE       = 8'h00;
    localparam logic [7:0] OP_CODE_DATA_POINTER_REG  = 8'h93;
    localparam logic [7:0] OP_FAR_JUMP   = 8'h02;
    localparam logic [7:0] OP_BIT_SET    = 8'hD2;
    localparam logic [7:0] OP_BIT_CLEAR  = 8'hC2;
    localparam logic [7:0] OP_BIT_INVERT = 8'hB2;
    localparam logic [7:0] OP_BIT_CARRY  = 8'h92;
    localparam logic [7:0] OP_BIT_BRCLR  = 8'h10;

    // how a port bit op alters the addressed bit
    typedef enum logic [2:0] {
        CIT_BIT_NONE   = 3'b000,
        CIT_BIT_CLEAR  = 3'b001,
        CIT_BIT_SET    = 3'b010,
        CIT_BIT_INVERT = 3'b011,
        CIT_BIT_CARRY  = 3'b100
    } cit_bitop_t;

    // decoded timing and operand class of one opcode
    typedef struct packed {
        logic                known;
        logic [BYTES_W-1:0]  bytes;
        logic [CYCLES_W-1:0] cycles;
        logic                rmw;
        cit_bitop_t          bitop;
    } cit_dec_t;

    // add result with its three flags
    typedef struct packed {
        logic [7:0] sum;
        logic       carry;
        logic       signed_wrap_flag;
        logic       half_carry_flag;
    } cit_add_t;

    // whole state of the sequencer
    typedef struct packed {
        logic                busy;
        logic                last;
        logic [CYCLES_W-1:0] count;
        logic [CYCLES_W-1:0] cycles;
        logic [BYTES_W-1:0]  bytes;
        logic                known;
        logic [7:0]          opcode;
        logic                from_latch;
        logic [7:0]          operand;
        logic                wb_strobe;
        logic [7:0]          wb_byte;
        cit_add_t            add;
    } cit_state_t;

endpackage : cit_pkg

/* File: core/cit_core.sv */
/*
 * Instruction timing sequencer with port read-modify-write operand
 * selection, port bit write-back and the add flag generator.
 * Assumes the fetch unit only offers an opcode while ready is seen,
 * that dest_port is decoded from the operand address by the caller,
 * and that all inputs are synchronous to clk.
 */
`timescale 1ns/1ns
module cit_core (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          fetch_valid,
    input  wire logic [7:0]                    opcode,
    input  wire logic                          dest_port,
    input  wire logic [7:0]                    pin_val,
    input  wire logic [7:0]                    latch_val,
    input  wire logic [2:0]                    bit_sel,
    input  wire logic                          carry_in,
    input  wire logic                          add_go,
    input  wire logic [7:0]                    add_a,
    input  wire logic [7:0]                    add_b,
    output logic                               busy,
    output logic                               last_cycle,
    output logic [cit_pkg::CYCLES_W-1:0]       cycle_num,
    output logic [cit_pkg::CYCLES_W-1:0]       instr_cycles,
    output logic [cit_pkg::BYTES_W-1:0]        instr_bytes,
    output logic                               instr_known,
    output logic                               operand_from_latch,
    output logic [7:0]                         operand,
    output logic                               wb_strobe,
    output logic [7:0]                         wb_byte,
    output logic [7:0]                         add_sum,
    output logic                               flag_carry,
    output logic                               signed_wrap_flag,
    output logic                               half_carry_flag
);

    cit_pkg::cit_state_t st;
    cit_pkg::cit_state_t next_st;
    cit_pkg::cit_dec_t   dec;
    logic                accept;
    logic [8:0]          add_full;
    logic [4:0]          add_low;
    logic [7:0]          add_mid;
    logic [7:0]          bit_mask;

    // opcode to length, cycle count and operand class
    function automatic cit_pkg::cit_dec_t decode(input logic [7:0] op);
        cit_pkg::cit_dec_t d;
        d = '{known: 1'b1, bytes: 2'h1, cycles: 3'h1, rmw: 1'b0,
              bitop: cit_pkg::CIT_BIT_NONE};
        casez (op)
            8'h00, 8'h03, 8'h13, 8'h23, 8'h33:
                d.cycles = 3'h1;
            8'b1110_1???, 8'b1111_1???, 8'b1100_1???:
                d.cycles = 3'h1;
            8'hC3, 8'hD3, 8'hB3:
                d.cycles = 3'h1;
            8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7:
                d.cycles = 3'h2;
            8'hD6, 8'hD7:
                d.cycles = 3'h2;
            8'hE5, 8'h74, 8'b0111_1???, 8'hF5, 8'b1010_1???,
            8'b1000_1???, 8'h76, 8'h77, 8'h86, 8'h87, 8'hA6,
            8'hA7, 8'hC5: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
            end
            8'h85, 8'h75, 8'h90: begin
                d.bytes  = 2'h3;
                d.cycles = 3'h3;
            end
            8'h93, 8'h83:
                d.cycles = 3'h4;
            8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
                d.cycles = 3'h4;
            8'hC0, 8'hD0: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
            end
            8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
            end
            8'hC2: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
                d.rmw    = 1'b1;
                d.bitop  = cit_pkg::CIT_BIT_CLEAR;
            end
            8'hD2: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
                d.rmw    = 1'b1;
                d.bitop  = cit_pkg::CIT_BIT_SET;
            end
            8'hB2: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
                d.rmw    = 1'b1;
                d.bitop  = cit_pkg::CIT_BIT_INVERT;
            end
            8'h92: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
                d.rmw    = 1'b1;
                d.bitop  = cit_pkg::CIT_BIT_CARRY;
            end
            8'h73:
                d.cycles = 3'h3;
            8'h22, 8'h32:
                d.cycles = 3'h4;
            8'b???1_0001, 8'b???0_0001, 8'h80, 8'h50, 8'h60,
            8'h70, 8'b1101_1???: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h3;
            end
            8'h02, 8'h12, 8'h20, 8'h30, 8'hB5, 8'hB4,
            8'b1011_1???, 8'hB6, 8'hB7: begin
                d.bytes  = 2'h3;
                d.cycles = 3'h4;
            end
            8'h10: begin
                d.bytes  = 2'h3;
                d.cycles = 3'h4;
                d.rmw    = 1'b1;
                d.bitop  = cit_pkg::CIT_BIT_CLEAR;
            end
            8'hD5: begin
                d.bytes  = 2'h3;
                d.cycles = 3'h4;
                d.rmw    = 1'b1;
            end
            8'h52, 8'h42, 8'h62, 8'h05, 8'h15: begin
                d.bytes  = 2'h2;
                d.cycles = 3'h2;
                d.rmw    = 1'b1;
            end
            8'h53, 8'h43, 8'h63: begin
                d.bytes  = 2'h3;
                d.cycles = 3'h3;
                d.rmw    = 1'b1;
            end
            // timing rows kept by the arithmetic decoder, not here
            default:
                d.known  = 1'b0;
        endcase
        return d;
    endfunction : decode

    assign dec      = decode(opcode);
    // a new opcode is taken when idle or in the last cycle
    assign accept   = ce && fetch_valid && (!st.busy || st.last);
    // add terms: incoming carry never enters the sum
    assign add_full = {1'b0, add_a} + {1'b0, add_b};
    assign add_low  = {1'b0, add_a[cit_pkg::HALF_BIT:0]}
                    + {1'b0, add_b[cit_pkg::HALF_BIT:0]};
    assign add_mid  = {1'b0, add_a[cit_pkg::WRAP_BIT:0]}
                    + {1'b0, add_b[cit_pkg::WRAP_BIT:0]};
    assign bit_mask = 8'h01 << bit_sel;

    // next state of the whole sequencer
    always_comb begin
        next_st           = st;
        next_st.wb_strobe = 1'b0;
        if (ce) begin
            if (accept) begin
                next_st.busy   = 1'b1;
                next_st.count  = cit_pkg::COUNT_ONE;
                next_st.last   = (dec.cycles == cit_pkg::COUNT_ONE);
                next_st.cycles = dec.cycles;
                next_st.bytes  = dec.bytes;
                next_st.known  = dec.known;
                next_st.opcode = opcode;
                // latch only for modify ops aimed at a port
                next_st.from_latch = dec.rmw && dest_port;
                next_st.operand    = (dec.rmw && dest_port) ? latch_val
                                                            : pin_val;
                // whole latched byte goes back with one bit altered
                if (dec.bitop != cit_pkg::CIT_BIT_NONE && dest_port) begin
                    next_st.wb_strobe = 1'b1;
                    unique case (dec.bitop)
                        cit_pkg::CIT_BIT_CLEAR:
                            next_st.wb_byte = latch_val & ~bit_mask;
                        cit_pkg::CIT_BIT_SET:
                            next_st.wb_byte = latch_val | bit_mask;
                        cit_pkg::CIT_BIT_INVERT:
                            next_st.wb_byte = latch_val ^ bit_mask;
                        cit_pkg::CIT_BIT_CARRY:
                            next_st.wb_byte = carry_in ? (latch_val | bit_mask)
                                                       : (latch_val & ~bit_mask);
                        default:
                            next_st.wb_byte = latch_val;
                    endcase
                end
            end else if (st.busy) begin
                if (st.last) begin
                    next_st.busy = 1'b0;
                    next_st.last = 1'b0;
                end else begin
                    next_st.count = st.count + cit_pkg::COUNT_ONE;
                    // last once the count just taken reaches the length
                    next_st.last  = (st.count + cit_pkg::COUNT_ONE) == st.cycles;
                end
            end
            // flags come only from the raw carries of the add
            if (add_go) begin
                next_st.add.sum              = add_full[7:0];
                next_st.add.carry            = add_full[cit_pkg::TOP_BIT+1];
                next_st.add.signed_wrap_flag = add_mid[cit_pkg::WRAP_BIT+1]
                                             ^ add_full[cit_pkg::TOP_BIT+1];
                next_st.add.half_carry_flag  = add_low[cit_pkg::HALF_BIT+1];
            end
        end
    end

    // one register for all state; ce low freezes it, strobe included
    always_ff @(posedge clk) begin
        if (rst) begin
            st        <= '0;
            st.cycles <= cit_pkg::CYCLES_RST;
            st.bytes  <= cit_pkg::BYTES_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign busy               = st.busy;
    assign last_cycle         = st.last;
    assign cycle_num          = st.count;
    assign instr_cycles       = st.cycles;
    assign instr_bytes        = st.bytes;
    assign instr_known        = st.known;
    assign operand_from_latch = st.from_latch;
    assign operand            = st.operand;
    assign wb_strobe          = st.wb_strobe;
    assign wb_byte            = st.wb_byte;
    assign add_sum            = st.add.sum;
    assign flag_carry         = st.add.carry;
    assign signed_wrap_flag   = st.add.signed_wrap_flag;
    assign half_carry_flag    = st.add.half_carry_flag;

    // checks on timing, operand source, port bit write-back and add flags
    a_idle_one_cycle: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == cit_pkg::OP_IDLE
        |=> instr_cycles == 3'h1 && instr_bytes == 2'h1 && last_cycle)
        else $error("idle op not one byte one cycle");

    a_indirect_move_two: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'hE6
        |=> instr_cycles == 3'h2 && instr_bytes == 2'h1)
        else $error("indirect move not one byte two cycles");

    a_direct_move_two: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'hE5
        |=> instr_cycles == 3'h2 && instr_bytes == 2'h2)
        else $error("direct move not two bytes two cycles");

    a_long_move_three: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'h85
        |=> instr_cycles == 3'h3 && instr_bytes == 2'h3)
        else $error("direct to direct move not three bytes three cycles");

    a_code_fetch_four: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == cit_pkg::OP_CODE_DATA_POINTER_REG
        |=> instr_cycles == 3'h4 && instr_bytes == 2'h1)
        else $error("code fetch not four cycles");

    a_stack_push_two: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'hC0
        |=> instr_cycles == 3'h2 && instr_bytes == 2'h2)
        else $error("stack push not two bytes two cycles");

    a_nibble_swap_two: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'hD6
        |=> instr_cycles == 3'h2 && instr_bytes == 2'h1)
        else $error("nibble swap not one byte two cycles");

    a_bit_clear_two: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == cit_pkg::OP_BIT_CLEAR
        |=> instr_cycles == 3'h2 && instr_bytes == 2'h2)
        else $error("bit clear not two bytes two cycles");

    a_sub_exit_four: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'h22
        |=> instr_cycles == 3'h4 && instr_bytes == 2'h1)
        else $error("subroutine exit not one byte four cycles");

    a_rel_jump_three: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == 8'h80
        |=> instr_cycles == 3'h3 && instr_bytes == 2'h2)
        else $error("relative jump not two bytes three cycles");

    a_far_jump_four: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == cit_pkg::OP_FAR_JUMP
        |=> instr_cycles == 3'h4 && instr_bytes == 2'h3)
        else $error("far jump not three bytes four cycles");

    a_last_at_count: assert property (@(posedge clk) disable iff (rst)
        busy && last_cycle |-> cycle_num == instr_cycles)
        else $error("last cycle flagged at wrong count");

    a_four_cycle_walk: assert property (@(posedge clk) disable iff (rst)
        accept && dec.cycles == 3'h4 ##1 ce[*3]
        |=> last_cycle && cycle_num == 3'h4)
        else $error("four cycle instruction did not end on time");

    a_latch_for_rmw: assert property (@(posedge clk) disable iff (rst)
        accept && dec.rmw && dest_port
        |=> operand_from_latch && operand == $past(latch_val))
        else $error("port modify op did not read the latch");

    a_port_logic_latch: assert property (@(posedge clk) disable iff (rst)
        accept && dest_port && opcode == 8'h53
        |=> operand_from_latch && instr_bytes == 2'h3 && instr_cycles == 3'h3)
        else $error("port logic op did not read the latch");

    a_pin_for_input: assert property (@(posedge clk) disable iff (rst)
        accept && !dec.rmw
        |=> !operand_from_latch && operand == $past(pin_val))
        else $error("port input did not read the pin");

    a_bit_set_byte: assert property (@(posedge clk) disable iff (rst)
        accept && opcode == cit_pkg::OP_BIT_SET && dest_port
        |=> wb_strobe && wb_byte == ($past(latch_val) | (8'h01 << $past(bit_sel))))
        else $error("port bit set wrote wrong byte");

    a_strobe_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wb_strobe && ce
        |=> !wb_strobe)
        else $error("write strobe longer than one cycle");

    a_add_carry_out: assert property (@(posedge clk) disable iff (rst)
        ce && add_go |=> flag_carry == (({1'b0, $past(add_a)} + {1'b0, $past(add_b)}) > 9'h0FF)
                     && add_sum == $past(add_a) + $past(add_b))
        else $error("add carry or sum wrong");

    a_add_wrap_flag: assert property (@(posedge clk) disable iff (rst)
        ce && add_go |=> signed_wrap_flag
            == ($past(add_a[7]) == $past(add_b[7]) && add_sum[7] != $past(add_a[7])))
        else $error("signed wrap flag wrong");

    a_add_half_carry: assert property (@(posedge clk) disable iff (rst)
        ce && add_go |=> half_carry_flag
            == (({1'b0, $past(add_a[3:0])} + {1'b0, $past(add_b[3:0])}) > 5'h0F))
        else $error("half carry flag wrong");

endmodule : cit_core

/* File: dv/tb_cpu_instruction_timing_rmw.sv */
/*
 * Self-checking bench for the instruction timing and port read-modify-write
 * sequencer: timing table, operand source, port bit write-back, add flags.
 * Assumes cit_core and cit_pkg are compiled first; inputs move at falling edges.
 */
`timescale 1ns/1ns
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", name, exp, got); end end
module tb_cpu_instruction_timing_rmw;

    logic                          clk = 1'b0;
    logic                          rst = 1'b1;
    logic                          ce = 1'b1;
    logic                          fetch_valid = 1'b0;
    logic [7:0]                    opcode = 8'h00;
    logic                          dest_port = 1'b0;
    logic [7:0]                    pin_val = 8'h00;
    logic [7:0]                    latch_val = 8'h00;
    logic [2:0]                    bit_sel = 3'h0;
    logic                          carry_in = 1'b0;
    logic                          add_go = 1'b0;
    logic [7:0]                    add_a = 8'h00;
    logic [7:0]                    add_b = 8'h00;
    logic                          busy, last_cycle, instr_known, operand_from_latch, wb_strobe;
    logic [cit_pkg::CYCLES_W-1:0]  cycle_num, instr_cycles;
    logic [cit_pkg::BYTES_W-1:0]   instr_bytes;
    logic [7:0]                    operand, wb_byte, add_sum;
    logic                          flag_carry, signed_wrap_flag, half_carry_flag;
    int                            err_total = 0;
    int                            samples_checked = 0;

    // opcode, byte count, cycle count; 64 entries grouped by timing
    localparam logic [15:0] TBL [64] = '{
        16'h3311, 16'h0311, 16'h1311, 16'hE811, 16'hF811, 16'hC811, 16'hC311, 16'hD311,
        16'hB311, 16'h0011,
        16'hE612, 16'hF612, 16'hC612, 16'hD612,
        16'hE522, 16'h7422, 16'h7822, 16'hF522, 16'hA822, 16'h8822, 16'h7622, 16'h8622,
        16'hA622, 16'hC522,
        16'h8533, 16'h7533, 16'h9033,
        16'h9314, 16'h8314, 16'hE214, 16'hE014, 16'hF214, 16'hF014,
        16'hC022, 16'hD022,
        16'hC222, 16'hD222, 16'hB222, 16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222,
        16'h9222, 16'h7313, 16'h2214, 16'h3214,
        16'h1123, 16'h0123, 16'h8023, 16'h5023, 16'h6023, 16'h7023, 16'hD823,
        16'h0234, 16'h1234, 16'h2034, 16'h3034, 16'h1034, 16'hB534, 16'hB434, 16'hB834,
        16'hB634, 16'hD534};

    cit_core i_cit_core (
        .clk(clk), .rst(rst), .ce(ce), .fetch_valid(fetch_valid), .opcode(opcode),
        .dest_port(dest_port), .pin_val(pin_val), .latch_val(latch_val), .bit_sel(bit_sel),
        .carry_in(carry_in), .add_go(add_go), .add_a(add_a), .add_b(add_b), .busy(busy),
        .last_cycle(last_cycle), .cycle_num(cycle_num), .instr_cycles(instr_cycles),
        .instr_bytes(instr_bytes), .instr_known(instr_known),
        .operand_from_latch(operand_from_latch), .operand(operand), .wb_strobe(wb_strobe),
        .wb_byte(wb_byte), .add_sum(add_sum), .flag_carry(flag_carry),
        .signed_wrap_flag(signed_wrap_flag), .half_carry_flag(half_carry_flag));

    // free-running core clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end

    // offer one opcode at a falling edge; returns in the instruction's first cycle
    task automatic issue(input logic [7:0] op, input logic dp);
        fetch_valid = 1'b1;
        opcode = op;
        dest_port = dp;
        @(negedge clk);
        fetch_valid = 1'b0;
    endtask : issue

    // step to the last cycle, bounded so a stuck counter cannot hang the run
    task automatic run_out(output int n);
        n = 1;
        while (last_cycle !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
    endtask : run_out

    // each opcode of the table issued back to back in the previous one's last cycle
    task automatic test_timing();
        int n;
        foreach (TBL[i]) begin
            issue(TBL[i][15:8], 1'b0);
            `CHK("bytes", TBL[i][5:4], instr_bytes)
            `CHK("cycles", TBL[i][2:0], instr_cycles)
            `CHK("first cycle", 3'h1, cycle_num)
            `CHK("known", 1'b1, instr_known)
            run_out(n);
            `CHK("cycle count", TBL[i][2:0], n[2:0])
        end
        @(negedge clk);
        `CHK("idle after run", 1'b0, busy)
        issue(8'h40, 1'b0);
        `CHK("unknown op", 1'b0, instr_known)
        `CHK("unknown cycles", 3'h1, instr_cycles)
        $display("test timing done");
    endtask : test_timing

    // refused fetch mid-instruction and a clock-enable stall
    task automatic test_hold();
        int n;
        issue(8'hE0, 1'b0);
        fetch_valid = 1'b1;
        opcode = 8'h00;
        @(negedge clk);
        fetch_valid = 1'b0;
        `CHK("refused fetch", 3'h4, instr_cycles)
        ce = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("stalled count", 3'h2, cycle_num)
        ce = 1'b1;
        run_out(n);
        `CHK("stall length", 5'h03, n[4:0])
        $display("test hold done");
    endtask : test_hold

    // latch versus pin as the operand source
    task automatic test_operand();
        int n;
        logic [7:0] rmw [14] = '{8'h52, 8'h53, 8'h42, 8'h43, 8'h62, 8'h63, 8'h05,
                                 8'h15, 8'hD5, 8'h10, 8'hB2, 8'hC2, 8'hD2, 8'h92};
        pin_val = 8'h0F;
        latch_val = 8'hF0;
        foreach (rmw[i]) begin
            issue(rmw[i], 1'b1);
            `CHK("rmw source", 1'b1, operand_from_latch)
            `CHK("rmw operand", 8'hF0, operand)
            run_out(n);
        end
        issue(8'hA2, 1'b1);
        `CHK("pin source", 1'b0, operand_from_latch)
        `CHK("pin operand", 8'h0F, operand)
        run_out(n);
        issue(8'h52, 1'b0);
        `CHK("non-port operand", 8'h0F, operand)
        run_out(n);
        $display("test operand done");
    endtask : test_operand

    // port bit ops rewrite the whole latched byte with one bit changed
    task automatic test_bitop();
        int n;
        logic [27:0] cases [7] = '{{8'hD2, 4'h3, 8'h00, 8'h08}, {8'hC2, 4'h0, 8'hFF, 8'hFE},
                                   {8'hB2, 4'h7, 8'h5A, 8'hDA}, {8'h92, 4'hA, 8'h00, 8'h04},
                                   {8'h92, 4'h5, 8'hFF, 8'hDF}, {8'h10, 4'h1, 8'hFF, 8'hFD},
                                   {8'hB2, 4'h4, 8'h3C, 8'h2C}};
        foreach (cases[i]) begin
            bit_sel = cases[i][18:16];
            carry_in = cases[i][19];
            latch_val = cases[i][15:8];
            issue(cases[i][27:20], 1'b1);
            `CHK("write strobe", 1'b1, wb_strobe)
            `CHK("write byte", cases[i][7:0], wb_byte)
            @(negedge clk);
            `CHK("strobe width", 1'b0, wb_strobe)
            run_out(n);
        end
        latch_val = 8'h00;
        issue(8'hD2, 1'b0);
        `CHK("no port strobe", 1'b0, wb_strobe)
        `CHK("byte kept", 8'h2C, wb_byte)
        run_out(n);
        $display("test bit op done");
    endtask : test_bitop

    // add flags from the carries out of bits 3, 6 and 7; incoming carry set
    task automatic test_add();
        logic [15:0] pairs [8] = '{16'h7F01, 16'hFF01, 16'h8080, 16'h0808,
                                   16'h0000, 16'h0F01, 16'hC040, 16'h40C1};
        logic [8:0] full;
        logic       c3, c6;
        foreach (pairs[i]) begin
            add_a = pairs[i][15:8];
            add_b = pairs[i][7:0];
            carry_in = 1'b1;
            add_go = 1'b1;
            full = {1'b0, add_a} + {1'b0, add_b};
            c3 = ({1'b0, add_a[3:0]} + {1'b0, add_b[3:0]}) > 5'h0F;
            c6 = ({1'b0, add_a[6:0]} + {1'b0, add_b[6:0]}) > 8'h7F;
            @(negedge clk);
            add_go = 1'b0;
            `CHK("sum", full[7:0], add_sum)
            `CHK("carry", full[8], flag_carry)
            `CHK("wrap", c6 ^ full[8], signed_wrap_flag)
            `CHK("half", c3, half_carry_flag)
        end
        $display("test add done");
    endtask : test_add

    // one place that reports and ends the run
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(negedge clk);
        `CHK("reset cycles", 3'h1, instr_cycles)
        `CHK("reset busy", 1'b0, busy)
        rst = 1'b0;
        test_timing();
        test_hold();
        test_operand();
        test_bitop();
        test_add();
        summarize();
    end

    // watchdog: the tests need well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end

endmodule : tb_cpu_instruction_timing_rmw
